/* rtl/nvs_slave.sv */
`timescale 1ns/1ps
module nvs_slave #(
  parameter logic [nvs_pkg::TYPE_W-1:0] DEV_TYPE = 4'h6  // Arbitrary value
) (
  // System clock and control
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Two-wire bus
  input  wire logic                         scl,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe_n,
  // Straps
  input  wire logic [nvs_pkg::SEL_W-1:0]    device_select_pins,
  input  wire logic                         wp
);
  import nvs_pkg::*;

  // Link side: bits captured on the rising bus clock
  logic lk_bit_q = 1'b0;
  logic lk_tgl_q = 1'b0;
  logic lk_bit_d;
  logic lk_tgl_d;

  always_comb begin
    lk_bit_d = sda_i;
    lk_tgl_d = ~lk_tgl_q;
  end

  always_ff @(posedge scl) begin
    lk_bit_q <= lk_bit_d;
    lk_tgl_q <= lk_tgl_d;
  end

  // Synchronisers into the system clock
  logic             scl_s1_q;
  logic             scl_s2_q;
  logic             scl_s3_q;
  logic             sda_s1_q;
  logic             sda_s2_q;
  logic             sda_s3_q;
  logic             tgl_s1_q;
  logic             tgl_s2_q;
  logic             tgl_s3_q;
  logic             tgl_s4_q;
  logic             bit_s1_q;
  logic             bit_s2_q;
  logic [SEL_W-1:0] sel_s1_q;
  logic [SEL_W-1:0] sel_s2_q;
  logic             wp_s1_q;
  logic             wp_s2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      tgl_s4_q <= 1'b0;
      bit_s1_q <= 1'b1;
      bit_s2_q <= 1'b1;
      sel_s1_q <= '0;
      sel_s2_q <= '0;
      wp_s1_q  <= 1'b0;
      wp_s2_q  <= 1'b0;
    end else if (ce) begin
      scl_s1_q <= scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      tgl_s1_q <= lk_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      tgl_s4_q <= tgl_s3_q;
      bit_s1_q <= lk_bit_q;
      bit_s2_q <= bit_s1_q;
      sel_s1_q <= device_select_pins;
      sel_s2_q <= sel_s1_q;
      wp_s1_q  <= wp;
      wp_s2_q  <= wp_s1_q;
    end
  end

  // Bus events
  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic bit_ev;
  logic bit_v;

  // Bit value had one extra cycle to settle behind its toggle
  assign start_ev = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_ev  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
  assign fall_ev  = scl_s3_q && !scl_s2_q;
  assign bit_ev   = tgl_s3_q ^ tgl_s4_q;
  assign bit_v    = bit_s2_q;

  // Array and write buffer
  logic              push;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [BUF_W-1:0]  buf_out_data;
  logic              drain_ready;
  logic [DATA_W-1:0] rd_data;

  // Array writes wait out the cycle where read data is loaded
  assign drain_ready = !fall_ev;

  // Protocol state
  nvs_state_e          st_q;
  nvs_state_e          st_d;
  nvs_state_e          nxt_q;
  nvs_state_e          nxt_d;
  logic [DATA_W-1:0]   sh_q;
  logic [DATA_W-1:0]   sh_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic [ADDR_W-1:0]   addr_q;
  logic [ADDR_W-1:0]   addr_d;
  logic [ADDR_HI_W-1:0] hi_q;
  logic [ADDR_HI_W-1:0] hi_d;
  logic                oe_n_q;
  logic                oe_n_d;
  logic                sda_o_q;
  logic                rx_state;

  assign rx_state = (st_q == ST_DEV) || (st_q == ST_AHI) || (st_q == ST_ALO) ||
                    (st_q == ST_WR) || (st_q == ST_MACK);

  always_comb begin
    st_d   = st_q;
    nxt_d  = nxt_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    addr_d = addr_q;
    hi_d   = hi_q;
    oe_n_d = oe_n_q;
    push   = 1'b0;
    if (start_ev) begin
      st_d   = ST_DEV;
      cnt_d  = CNT_ZERO;
      oe_n_d = 1'b1;
    end else if (stop_ev) begin
      st_d   = ST_IDLE;
      oe_n_d = 1'b1;
    end else begin
      if (bit_ev && rx_state) begin
        sh_d  = {sh_q[DATA_W-2:0], bit_v};
        cnt_d = cnt_q + CNT_ONE;
      end
      if (fall_ev) begin
        case (st_q)
          ST_DEV: begin
            if (cnt_q == CNT_BYTE) begin
              if (sh_q[DATA_W-1:SA_TYPE_LSB] == DEV_TYPE &&
                  sh_q[SA_TYPE_LSB-1:SA_SEL_LSB] == sel_s2_q) begin
                st_d   = ST_DACK;
                oe_n_d = 1'b0;
                nxt_d  = sh_q[SA_RW_BIT] ? ST_RD : ST_AHI;
              end else begin
                st_d = ST_IDLE;
              end
            end
          end
          ST_AHI: begin
            if (cnt_q == CNT_BYTE) begin
              hi_d   = sh_q[ADDR_HI_W-1:0];
              st_d   = ST_DACK;
              oe_n_d = 1'b0;
              nxt_d  = ST_ALO;
            end
          end
          ST_ALO: begin
            if (cnt_q == CNT_BYTE) begin
              addr_d = {hi_q, sh_q};
              st_d   = ST_DACK;
              oe_n_d = 1'b0;
              nxt_d  = ST_WR;
            end
          end
          ST_WR: begin
            if (cnt_q == CNT_BYTE) begin
              if (wp_s2_q || !buf_in_ready) begin
                st_d = ST_IDLE;
              end else begin
                push   = 1'b1;
                addr_d = nvs_addr_inc(addr_q);
                st_d   = ST_DACK;
                oe_n_d = 1'b0;
                nxt_d  = ST_WR;
              end
            end
          end
          ST_DACK: begin
            oe_n_d = 1'b1;
            cnt_d  = CNT_ZERO;
            st_d   = nxt_q;
            if (nxt_q == ST_RD) begin
              sh_d   = rd_data;
              oe_n_d = rd_data[DATA_W-1];
              cnt_d  = CNT_ONE;
            end
          end
          ST_RD: begin
            if (cnt_q == CNT_BYTE) begin
              oe_n_d = 1'b1;
              addr_d = nvs_addr_inc(addr_q);
              cnt_d  = CNT_ZERO;
              st_d   = ST_MACK;
            end else begin
              oe_n_d = sh_q[DATA_W-2];
              sh_d   = {sh_q[DATA_W-2:0], 1'b0};
              cnt_d  = cnt_q + CNT_ONE;
            end
          end
          ST_MACK: begin
            if (cnt_q == CNT_ONE && !sh_q[0]) begin
              sh_d   = rd_data;
              oe_n_d = rd_data[DATA_W-1];
              cnt_d  = CNT_ONE;
              st_d   = ST_RD;
            end else begin
              oe_n_d = 1'b1;
              st_d   = ST_IDLE;
            end
          end
          ST_IDLE: begin
            oe_n_d = 1'b1;
          end
          default: begin
            oe_n_d = 1'b1;
            st_d   = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      nxt_q   <= ST_IDLE;
      sh_q    <= DATA_RST;
      cnt_q   <= CNT_ZERO;
      addr_q  <= ADDR_RST;
      hi_q    <= '0;
      oe_n_q  <= 1'b1;
      sda_o_q <= 1'b0;
    end else if (ce) begin
      st_q    <= st_d;
      nxt_q   <= nxt_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      hi_q    <= hi_d;
      oe_n_q  <= oe_n_d;
      sda_o_q <= 1'b0;
    end
  end

  // Pin outputs; nothing here ever clocks or starts the bus
  assign sda_o    = sda_o_q;
  assign sda_oe_n = oe_n_q;

  nvs_buf u_buf (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   ({addr_q, sh_q}),
    .out_valid (buf_out_valid),
    .out_ready (drain_ready),
    .out_data  (buf_out_data)
  );

  nvs_mem u_mem (
    .clk       (clk),
    .ce        (ce),
    .wr_en     (buf_out_valid && drain_ready),
    .wr_addr   (buf_out_data[BUF_W-1:DATA_W]),
    .wr_data   (buf_out_data[DATA_W-1:0]),
    .rd_addr   (addr_q),
    .rd_data_q (rd_data)
  );

endmodule

/* rtl/nvs_pkg.sv */
package nvs_pkg;

  // Array geometry
  localparam int          MEM_DEPTH   = 8192;
  localparam int          ADDR_W      = 13;
  localparam int          DATA_W      = 8;
  localparam int          ADDR_HI_W   = ADDR_W - DATA_W;
  localparam int          SEL_W       = 3;
  localparam int          TYPE_W      = 4;

  // Write buffer between the bus side and the array
  localparam int          BUF_W       = ADDR_W + DATA_W;
  localparam int          BUF_DEPTH   = 2;

  // Slave address byte layout
  localparam int          SA_TYPE_LSB = 4;
  localparam int          SA_SEL_LSB  = 1;
  localparam int          SA_RW_BIT   = 0;

  // Bit counter values
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [3:0]  CNT_BYTE    = 4'h8;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WR,
    ST_DACK,
    ST_RD,
    ST_MACK
  } nvs_state_e;

  function automatic logic [ADDR_W-1:0] nvs_addr_inc(input logic [ADDR_W-1:0] a);
    nvs_addr_inc = a + 13'h0001;
  endfunction

endpackage

/* rtl/nvs_mem.sv */
`timescale 1ns/1ps
module nvs_mem (
  // Clock
  input  wire logic                          clk,
  input  wire logic                          ce,
  // Write port
  input  wire logic                          wr_en,
  input  wire logic [nvs_pkg::ADDR_W-1:0]    wr_addr,
  input  wire logic [nvs_pkg::DATA_W-1:0]    wr_data,
  // Read port
  input  wire logic [nvs_pkg::ADDR_W-1:0]    rd_addr,
  output logic      [nvs_pkg::DATA_W-1:0]    rd_data_q
);
  import nvs_pkg::*;

  logic [DATA_W-1:0] mem_q [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule

/* rtl/nvs_buf.sv */
`timescale 1ns/1ps
module nvs_buf (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // Filling side
  input  wire logic                        in_valid,
  output logic                             in_ready,
  input  wire logic [nvs_pkg::BUF_W-1:0]   in_data,
  // Draining side
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic      [nvs_pkg::BUF_W-1:0]   out_data
);
  import nvs_pkg::*;

  logic [BUF_W-1:0] ent_q [BUF_DEPTH];
  logic [BUF_W-1:0] ent_d [BUF_DEPTH];
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = ent_q[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    ent_d[0] = ent_q[0];
    ent_d[1] = ent_q[1];
    cnt_d    = cnt_q;
    if (pop) begin
      ent_d[0] = ent_q[1];
      cnt_d    = cnt_d - 2'h1;
    end
    if (push) begin
      // Slot after the survivors of this cycle's pop
      if (cnt_d == 2'h0) begin
        ent_d[0] = in_data;
      end else begin
        ent_d[1] = in_data;
      end
      cnt_d = cnt_d + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q    <= 2'h0;
      ent_q[0] <= '0;
      ent_q[1] <= '0;
    end else if (ce) begin
      cnt_q    <= cnt_d;
      ent_q[0] <= ent_d[0];
      ent_q[1] <= ent_d[1];
    end
  end

endmodule

/* verif/nvs_slave_checker.sv */
`timescale 1ns/1ps
module nvs_slave_checker (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      ce,
  // Two-wire bus
  input wire logic                      scl,
  input wire logic                      sda_i,
  input wire logic                      sda_o,
  input wire logic                      sda_oe_n,
  // Straps
  input wire logic [nvs_pkg::SEL_W-1:0] device_select_pins,
  input wire logic                      wp
);
  import nvs_pkg::*;
  localparam int DRV_MAX = 48;
  logic       scl_q;
  logic       scl_d;
  logic [7:0] fall_q;
  logic [7:0] fall_d;
  // Cycles since the last bus clock fall
  always_comb begin
    scl_d  = rst ? 1'b1 : scl;
    fall_d = (fall_q == 8'hff) ? fall_q : fall_q + 8'h01;
    if (rst) begin
      fall_d = 8'hff;
    end else if (scl_q && !scl) begin
      fall_d = 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    scl_q  <= scl_d;
    fall_q <= fall_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start; scl && $past(scl) && $fell(sda_i); endsequence
  sequence s_stop; scl && $past(scl) && $rose(sda_i); endsequence
  sequence s_drive; $fell(sda_oe_n); endsequence
  property p_open_drain; sda_o == 1'b0; endproperty
  property p_reset_idle; $fell(rst) |-> sda_oe_n [*4]; endproperty
  property p_drive_low_phase; s_drive |-> !scl && fall_q >= 8'h02 && fall_q <= 8'h07; endproperty
  property p_ack_hold; s_drive |=> !sda_oe_n [*8]; endproperty
  property p_release_bounded; s_drive |-> ##[1:300] sda_oe_n; endproperty
  property p_stop_release; s_stop |=> sda_oe_n [*8]; endproperty
  property p_start_release; s_start |=> sda_oe_n [*8]; endproperty
  property p_drive_needs_clock; !sda_oe_n |-> fall_q <= DRV_MAX; endproperty
  property p_ce_freeze; !ce |=> $stable(sda_oe_n) && $stable(sda_o); endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
  a_reset_idle: assert property (p_reset_idle)
    else $error("data line driven after reset");
  a_drive_low_phase: assert property (p_drive_low_phase)
    else $error("drive began outside clock low phase");
  a_ack_hold: assert property (p_ack_hold)
    else $error("drive dropped too early");
  a_release_bounded: assert property (p_release_bounded)
    else $error("data line never released");
  a_stop_release: assert property (p_stop_release)
    else $error("drive after stop");
  a_start_release: assert property (p_start_release)
    else $error("drive after start");
  a_drive_needs_clock: assert property (p_drive_needs_clock)
    else $error("drive without bus clock");
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("data line moved while clock enable low");
endmodule
bind nvs_slave nvs_slave_checker u_chk (.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins), .wp(wp));

/* verif/nvs_master_model.sv */
`timescale 1ns/1ps
module nvs_master_model (
  // Link tick
  input wire logic lclk,
  // Two-wire bus
  input wire logic sda,
  output logic     scl,
  output logic     sda_m
);
  logic [8:0] res = 9'h000;
  int         res_n = 0;
  int         slow = 0;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_m <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_m <= 1'b1;
    tick(3);
  endtask
  // Data changes mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    tick(2 + slow);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mk);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(mk, a);
    res = {a, r};
    res_n = res_n + 1;
  endtask
endmodule

/* verif/tb_nvram_two_wire_slave.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_nvram_two_wire_slave;
  import nvs_pkg::*;
  localparam logic [TYPE_W-1:0] DT = 4'h9;  // Arbitrary value
  logic             clk = 1'b0;
  logic             lclk = 1'b0;
  logic             rst = 1'b1;
  logic             ce = 1'b1;
  logic             wp = 1'b0;
  logic [SEL_W-1:0] sel = 3'h0;
  wire              scl;
  wire              sda_m;
  wire              sda;
  wire              sda_o;
  wire              sda_oe_n;
  int               err_count = 0;
  int               checks_done = 0;
  int               seed = 32'hcf73;
  logic [8:0]       q[$];
  logic [8:0]       exp_v;
  logic [7:0]       shadow[int];
  assign sda = sda_m & (sda_oe_n ? 1'b1 : sda_o);
  always #5 clk = ~clk;
  always #16 lclk = ~lclk;
  nvs_slave #(.DEV_TYPE(DT)) uut (.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .device_select_pins(sel), .wp(wp));
  nvs_master_model m (.lclk(lclk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // Oldest note against each finished byte
  always @(m.res_n) begin
    exp_v = q.size() ? q.pop_front() : 9'hxxx;
    `CHK(m.res, exp_v)
  end
  task automatic xb(input logic [7:0] d, input logic mk, input logic [8:0] e);
    q.push_back(e);
    m.xfer(d, mk);
  endtask
  task automatic wr(input logic [7:0] d, input logic ea);
    xb(d, 1'b1, {ea, d});
  endtask
  task automatic rd(input logic [7:0] e, input logic mk);
    xb(8'hff, mk, {mk, e});
  endtask
  task automatic dev(input logic [2:0] s, input logic rw, input logic ea);
    wr({DT, s, rw}, ea);
  endtask
  task automatic seta(input logic [15:0] a);
    m.start();
    dev(sel, 1'b0, 1'b0);
    wr(a[15:8], 1'b0);
    wr(a[7:0], 1'b0);
  endtask
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] b;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      sel <= s[2:0];
      @(posedge clk);
      m.start();
      dev(s[2:0] ^ 3'h1, 1'b0, 1'b1);
      m.start();
      dev(s[2:0], 1'b0, 1'b0);
      m.stop();
    end
    m.start();
    wr({~DT, sel, 1'b0}, 1'b1);
    m.stop();
    fin("select");
    // Idle freeze: sda_oe_n and sda_o must hold while the enable is low
    @(posedge clk);
    ce <= 1'b0;
    repeat (8) @(posedge clk);
    ce <= 1'b1;
    b = 8'($random(seed));
    @(posedge clk);
    sel <= b[2:0];
    seta(16'hfffe);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      shadow[(8190 + i) % MEM_DEPTH] = b;
      wr(b, 1'b0);
    end
    m.stop();
    fin("write");
    m.slow = 2;
    seta(16'h1ffe);
    m.start();
    dev(sel, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(shadow[(8190 + i) % MEM_DEPTH], i == 3);
    end
    m.stop();
    m.slow = 0;
    fin("read");
    @(posedge clk);
    wp <= 1'b1;
    seta(16'h0001);
    wr(shadow[1] ^ 8'h5a, 1'b1);
    m.stop();
    @(posedge clk);
    wp <= 1'b0;
    m.start();
    dev(sel, 1'b1, 1'b0);
    rd(shadow[1], 1'b1);
    m.stop();
    fin("protect");
    seta(16'h0000);
    for (int i = 0; i < 4; i++) begin
      m.bit_io(1'b0, b[i]);
    end
    m.start();
    dev(sel, 1'b1, 1'b0);
    rd(shadow[0], 1'b1);
    m.stop();
    fin("abort");
    for (int i = 0; i < 1000 && q.size() > 0; i++) begin
      @(posedge clk);
    end
    `CHK(q.size(), 0)
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule
